// ### verilog/bie_pkg.sv
// Package: encodings, field positions and reset values for the jump/increment executor
package bie_pkg;
  localparam int          INSN_W        = 14;
  localparam int          PC_W          = 13;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 7;
  localparam int          LIT_W         = 11;
  // Jump: top three bits 101
  localparam int          JMP_OP_HI     = 13;
  localparam int          JMP_OP_LO     = 11;
  localparam logic [2:0]  JMP_OPCODE    = 3'h5;
  // Increment: top six bits 00 1010
  localparam int          INC_OP_HI     = 13;
  localparam int          INC_OP_LO     = 8;
  localparam logic [5:0]  INC_OPCODE    = 6'h0A;
  localparam int          DEST_BIT      = 7;
  localparam int          LATCH_HI      = 4;
  localparam int          LATCH_LO      = 3;
  localparam logic [0:0]  DEST_ACC      = 1'h0;
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic [PC_W-1:0]   PC_STEP   = 13'h0001;
  typedef enum logic [1:0] { BIE_OP_NONE, BIE_OP_JMP, BIE_OP_INC } bie_op_e;
endpackage : bie_pkg

// ### verilog/bie_decode.sv
// Instruction word decoder for jump and increment
`timescale 1ns/1ns
module bie_decode (
  input  wire logic [bie_pkg::INSN_W-1:0] insn,
  output bie_pkg::bie_op_e                op,
  output logic [bie_pkg::LIT_W-1:0]       literal,
  output logic [bie_pkg::ADDR_W-1:0]      reg_addr,
  output logic                            dest_sel
);
  // Opcode match and field extraction
  always_comb begin
    op = bie_pkg::BIE_OP_NONE;
    if (insn[bie_pkg::JMP_OP_HI:bie_pkg::JMP_OP_LO] == bie_pkg::JMP_OPCODE) begin
      op = bie_pkg::BIE_OP_JMP;
    end else if (insn[bie_pkg::INC_OP_HI:bie_pkg::INC_OP_LO] == bie_pkg::INC_OPCODE) begin
      op = bie_pkg::BIE_OP_INC;
    end
  end
  assign literal  = insn[bie_pkg::LIT_W-1:0];
  assign reg_addr = insn[bie_pkg::ADDR_W-1:0];
  assign dest_sel = insn[bie_pkg::DEST_BIT];
endmodule : bie_decode

// ### verilog/bie_core.sv
// Execute unit for the absolute jump and register increment instructions
// Summary of operation
// - Jump opcode 101 with 11-bit literal executes unconditionally, ignoring flags.
// - Jump copies the 11-bit literal into program counter bits 10..0.
// - Jump takes program counter bits 12..11 from upper latch bits 4..3.
// - Jump lasts two cycles; second discards prefetched word; no flags change.
// - Increment reads the register, adds one; the accumulator takes the result in one cycle, the register write-back a cycle later.
// - Increment carries a one-bit destination select and seven-bit address.
// - Destination 0 writes the accumulator; 1 writes back the register.
`timescale 1ns/1ns
module bie_core (
  input  wire logic                        clk,
  input  wire logic                        resetn,
  input  wire logic [bie_pkg::INSN_W-1:0]  insn,
  input  wire logic [bie_pkg::DATA_W-1:0]  pc_upper_latch,
  input  wire logic [bie_pkg::DATA_W-1:0]  rf_rdata,
  output logic [bie_pkg::PC_W-1:0]         pc,
  output logic [bie_pkg::DATA_W-1:0]       acc,
  output logic                             zero_flag,
  output logic                             flush,
  output logic [bie_pkg::ADDR_W-1:0]       rf_addr,
  output logic                             rf_we,
  output logic [bie_pkg::DATA_W-1:0]       rf_wdata
);
  bie_pkg::bie_op_e             op;
  logic [bie_pkg::LIT_W-1:0]    literal;
  logic [bie_pkg::ADDR_W-1:0]   dec_addr;
  logic                         dest_sel;
  logic [bie_pkg::DATA_W-1:0]   sum;
  logic                         do_jmp;
  logic                         do_inc;

  bie_decode u_decode (
    .insn     (insn),
    .op       (op),
    .literal  (literal),
    .reg_addr (dec_addr),
    .dest_sel (dest_sel)
  );

  // Execution phase: a jump word is followed by one discard cycle
  typedef enum logic { BIE_PH_EXEC, BIE_PH_DISCARD } bie_phase_e;

  bie_phase_e                                           phase;
  bie_phase_e                                           next_phase;
  logic                                                 is_jmp_word;
  logic                                                 is_inc_word;
  logic                                                 inc_to_acc;
  logic                                                 inc_to_rf;
  logic                                                 sum_is_zero;
  logic [bie_pkg::LATCH_HI-bie_pkg::LATCH_LO:0]         jmp_upper;
  logic [bie_pkg::PC_W-1:0]                             jmp_target;
  logic [bie_pkg::PC_W-1:0]                             seq_pc;
  logic [bie_pkg::PC_W-1:0]                             next_pc;
  logic [bie_pkg::DATA_W-1:0]                           next_acc;
  logic                                                 next_zero_flag;
  logic                                                 next_rf_we;
  logic [bie_pkg::DATA_W-1:0]                           next_rf_wdata;

  // Word classification straight from the decoder
  assign is_jmp_word = (op == bie_pkg::BIE_OP_JMP);
  assign is_inc_word = (op == bie_pkg::BIE_OP_INC);

  // Execute only outside the discard cycle; no flag takes part in the jump test
  assign do_jmp = (phase == BIE_PH_EXEC) && is_jmp_word;
  assign do_inc = (phase == BIE_PH_EXEC) && is_inc_word;

  // Destination select splits the increment result
  assign inc_to_acc = do_inc && (dest_sel == bie_pkg::DEST_ACC);
  assign inc_to_rf  = do_inc && (dest_sel != bie_pkg::DEST_ACC);

  // Incrementer, its zero test and the register file address
  assign sum         = rf_rdata + bie_pkg::DATA_ONE;
  assign sum_is_zero = (sum == bie_pkg::DATA_ZERO);
  assign rf_addr     = dec_addr;

  // Discard cycle is visible to the fetch side
  assign flush = (phase == BIE_PH_DISCARD);

  // Jump target: latch bits on top, literal below
  assign jmp_upper  = pc_upper_latch[bie_pkg::LATCH_HI:bie_pkg::LATCH_LO];
  assign jmp_target = {jmp_upper, literal};
  assign seq_pc     = pc + bie_pkg::PC_STEP;

  // Phase sequencing: one discard cycle after every executed jump
  always_comb begin
    next_phase = phase;
    unique case (phase)
      BIE_PH_EXEC: begin
        if (is_jmp_word) begin
          next_phase = BIE_PH_DISCARD;
        end
      end
      BIE_PH_DISCARD: begin
        next_phase = BIE_PH_EXEC; // Prefetched word is dropped
      end
    endcase
  end

  // Phase register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      phase <= BIE_PH_EXEC;
    end else begin
      phase <= next_phase;
    end
  end

  // Program counter: jump target or sequential step
  always_comb begin
    next_pc = seq_pc;
    unique case (op)
      bie_pkg::BIE_OP_JMP: begin
        if (do_jmp) begin
          next_pc = jmp_target;
        end
      end
      bie_pkg::BIE_OP_INC,
      bie_pkg::BIE_OP_NONE: begin
        next_pc = seq_pc;
      end
      default: begin
        next_pc = seq_pc; // Unused decoder code
      end
    endcase
  end

  // Program counter register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pc <= bie_pkg::PC_RESET;
    end else begin
      pc <= next_pc;
    end
  end

  // Accumulator takes the sum only for destination 0
  always_comb begin
    next_acc = acc;
    unique case (op)
      bie_pkg::BIE_OP_INC: begin
        if (inc_to_acc) begin
          next_acc = sum;
        end
      end
      bie_pkg::BIE_OP_JMP,
      bie_pkg::BIE_OP_NONE: begin
        next_acc = acc; // Jump and other words leave it alone
      end
      default: begin
        next_acc = acc; // Unused decoder code
      end
    endcase
  end

  // Accumulator register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      acc <= bie_pkg::ACC_RESET;
    end else begin
      acc <= next_acc;
    end
  end

  // Zero flag touched only by an executed increment
  always_comb begin
    next_zero_flag = zero_flag;
    unique case (op)
      bie_pkg::BIE_OP_INC: begin
        if (do_inc) begin
          next_zero_flag = sum_is_zero;
        end
      end
      bie_pkg::BIE_OP_JMP,
      bie_pkg::BIE_OP_NONE: begin
        next_zero_flag = zero_flag;
      end
      default: begin
        next_zero_flag = zero_flag; // Unused decoder code
      end
    endcase
  end

  // Zero flag register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      zero_flag <= 1'b0;
    end else begin
      zero_flag <= next_zero_flag;
    end
  end

  // Write strobe for destination 1, one cycle long
  always_comb begin
    next_rf_we = 1'b0;
    if (inc_to_rf) begin
      next_rf_we = 1'b1;
    end
  end

  // Write strobe register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rf_we <= 1'b0;
    end else begin
      rf_we <= next_rf_we;
    end
  end

  // Write data holds the last increment sum
  always_comb begin
    next_rf_wdata = rf_wdata;
    if (do_inc) begin
      next_rf_wdata = sum;
    end
  end

  // Write data register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rf_wdata <= bie_pkg::DATA_ZERO;
    end else begin
      rf_wdata <= next_rf_wdata;
    end
  end
endmodule : bie_core

// ### verif/bie_core_chk.sv
// Checker: port assertions of the jump/increment executor
`timescale 1ns/1ns
module bie_chk (
  input wire logic        clk, resetn, flush, zero_flag, rf_we,
  input wire logic [13:0] insn,
  input wire logic [7:0]  pc_upper_latch, rf_rdata, acc, rf_wdata,
  input wire logic [12:0] pc,
  input wire logic [6:0]  rf_addr
);
  // Words that really execute
  wire j = insn[13:11] == 3'h5 && !flush;
  wire i = insn[13:8] == 6'h0A && !flush;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_jump_target: assert property (j |=> pc == {$past(pc_upper_latch[4:3]), $past(insn[10:0])}) else $error("pc");
  a_jump_flush: assert property (j |=> flush && $stable(acc) && $stable(zero_flag) ##1 !flush) else $error("flush");
  a_discard_step: assert property (flush |=> pc == $past(pc) + 13'h0001 && !rf_we) else $error("skip");
  a_jump_always: assert property (j |=> !rf_we) else $error("jump");
  a_inc_acc: assert property (i && !insn[7] |=> acc == $past(rf_rdata) + 8'h01 && !rf_we) else $error("acc");
  a_inc_back: assert property (i && insn[7] |=> rf_we && rf_wdata == $past(rf_rdata) + 8'h01 && $stable(acc)) else $error("wb");
  a_inc_zero: assert property (i |=> zero_flag == ($past(rf_rdata) == 8'hFF)) else $error("z");
  a_addr_field: assert property (rf_addr == insn[6:0]) else $error("addr");
  c_jump: cover property (j);
  c_wrap: cover property (i && rf_rdata == 8'hFF);
  c_back: cover property (i && insn[7]);
endmodule : bie_chk
bind bie_core bie_chk u_chk (.*);

// ### verif/bie_rf.sv
// Register file model: combinational read, write-back lands one cycle late
`timescale 1ns/1ns
module bie_rf (
  input wire logic       clk, rf_we,
  input wire logic [6:0] rf_addr,
  input wire logic [7:0] rf_wdata,
  output logic [7:0]     rf_rdata
);
  logic [7:0] mem [128];
  logic [6:0] wa;
  initial for (int k = 0; k < 128; k++) mem[k] = 8'(k) - 8'h10;
  assign rf_rdata = mem[rf_addr];
  // Write goes to the address latched from the previous word, the increment that raised rf_we
  always @(posedge clk) begin wa <= rf_addr; if (rf_we) mem[wa] <= rf_wdata; end
endmodule : bie_rf

// ### verif/tb_top.sv
// Bench: random jump/increment stream against a cycle model
`timescale 1ns/1ns
module tb_top;
  logic        clk = 0, resetn = 0, flush, rf_we, zero_flag, f, w, z;
  logic [13:0] insn = 0;
  logic [7:0]  pc_upper_latch = 0, acc, rf_rdata, rf_wdata, a, v, d;
  logic [12:0] pc, p;
  logic [6:0]  rf_addr;
  logic [31:0] r, q[$];
  int          seed = 19403, n_errors = 0, num_checks = 0;
  always #50 clk = ~clk;
  bie_core u_dut (.*);
  bie_rf u_rf (.*);
  task check(input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin n_errors++; $display("MISMATCH %0t got %h want %h", $time, s, e); end
  endtask : check
  task test_done;
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Observer takes the oldest note
  always @(negedge clk) if (q.size() > 0) check({pc, acc, zero_flag, flush, rf_we, rf_we ? rf_wdata : 8'h00}, q.pop_front());
  // Driver: model the edge, note it, drive the next word
  initial begin
    for (int i = 0; i < 3000; i++) begin
      @(posedge clk);
      v = u_rf.mem[insn[6:0]] + 8'h01;
      w = 0;
      if (!resetn) {p, a, z, f, d} = 0;
      else if (f) {p, f} = {p + 13'h0001, 1'b0};
      else if (insn[13:11] == 3'h5) {p, f} = {pc_upper_latch[4:3], insn[10:0], 1'b1};
      else begin
        p = p + 13'h0001;
        if (insn[13:8] == 6'h0A) begin z = v == 0; w = insn[7]; if (w) d = v; else a = v; end
      end
      q.push_back({p, a, z, f, w, w ? d : 8'h00});
      r = $random(seed);
      resetn <= i > 0 && i != 1500;
      pc_upper_latch <= r[23:16];
      insn <= r[15] ? (r[14] ? {3'h5, r[10:0]} : {6'h0A, r[7:0]}) : r[13:0];
    end
    repeat (2) @(posedge clk);
    test_done();
  end
endmodule : tb_top
